/* flash_prog_pkg.sv */
// Constants and types shared by the flash program host and its cycle engine
package flash_prog_pkg;
    localparam int DQ_W = 16;
    localparam int LINE_LSB = 8;
    localparam int LINE_WORDS = 256;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam int FAIL_POLL_BIT = 5;
    localparam int ABORT_POLL_BIT = 1;
    localparam int COMPLETION_POLL_BIT = 7;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ADDR = 12'h008;
    localparam logic [11:0] REG_COUNT = 12'h00C;
    localparam logic [11:0] REG_BUF_BASE = 12'h400;
    localparam int BUF_IDX_LSB = 2;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_BUFFER_BIT = 1;
    localparam int CTRL_OVERLAY_BIT = 2;
    localparam int CTRL_FLASH_RST_BIT = 3;
    localparam logic [2:0] CTRL_RESET_VAL = 3'h0;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_FAIL_BIT = 2;
    localparam int STAT_ABORT_BIT = 3;
    localparam int STAT_REFUSED_BIT = 4;

    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;
    localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_WORD_PGM = 16'h00A0;
    localparam logic [15:0] CMD_WRITE_BUF = 16'h0025;
    localparam logic [15:0] CMD_CONFIRM = 16'h0029;
    localparam logic [15:0] CMD_RESET = 16'h00F0;

    localparam int CLK_PERIOD_NS = 8;
    localparam int T_WE_PULSE_NS = 35;
    localparam int T_WE_HIGH_NS = 20;
    localparam int T_READ_ACC_NS = 100;
    localparam int T_BUSY_NS = 90;
    localparam logic [7:0] WE_PULSE_CYC = 8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WE_HIGH_CYC = 8'((T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] READ_ACC_CYC = 8'((T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] BUSY_CYC = 8'((T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum {S_IDLE, S_UNLOCK1, S_UNLOCK2, S_SETUP, S_COUNT, S_LOAD, S_CONFIRM,
        S_WORD, S_WAIT_BUSY, S_POLL, S_RST_CMD} seq_state_t;
    typedef enum {E_IDLE, E_STROBE, E_RECOVER} eng_state_t;
endpackage

/* flash_cycle_if.sv */
// Request and answer between the sequencer and the flash cycle engine
`timescale 1ns/1ps
interface flash_cycle_if #(parameter int ADDR_W = 26);
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport seq (output req, output write, output addr, output wdata, input ack, input rdata);
    modport eng (input req, input write, input addr, input wdata, output ack, output rdata);
endinterface

/* flash_cycle_engine.sv */
// Single asynchronous flash write or read cycle timed in system clocks
`timescale 1ns/1ps
module flash_cycle_engine #(
    parameter int ADDR_W = 26
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    flash_cycle_if.eng cyc,
    input wire logic [flash_prog_pkg::DQ_W-1:0] i_dq_in,
    output logic [flash_prog_pkg::DQ_W-1:0] o_dq_out,
    output logic o_dq_oe,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n
);
    import flash_prog_pkg::*;

    eng_state_t state_r;
    logic [7:0] cnt_r;
    logic is_wr_r;

    // Ack stays one cycle; a request seen beside it is the one just served
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= E_IDLE;
            cnt_r <= 8'h00;
            is_wr_r <= 1'b0;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_dq_oe <= 1'b0;
            o_dq_out <= 16'h0000;
            o_addr <= '0;
            cyc.ack <= 1'b0;
            cyc.rdata <= 16'h0000;
        end
        else if (i_clk_en)
        begin
            cyc.ack <= 1'b0;
            case (state_r)
                E_IDLE:
                    if (cyc.req && !cyc.ack)
                    begin
                        o_addr <= cyc.addr;
                        o_dq_out <= cyc.wdata;
                        o_dq_oe <= cyc.write;
                        is_wr_r <= cyc.write;
                        o_ce_n <= 1'b0;
                        o_we_n <= !cyc.write;
                        o_oe_n <= cyc.write;
                        cnt_r <= cyc.write ? WE_PULSE_CYC : READ_ACC_CYC;
                        state_r <= E_STROBE;
                    end
                E_STROBE:
                    if (cnt_r == 8'h01)
                    begin
                        o_we_n <= 1'b1;
                        o_oe_n <= 1'b1;
                        o_ce_n <= 1'b1;
                        if (!is_wr_r)
                            cyc.rdata <= i_dq_in;
                        cnt_r <= WE_HIGH_CYC;
                        state_r <= E_RECOVER;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                E_RECOVER:
                    // Data held past the write strobe for hold time
                    if (cnt_r == 8'h01)
                    begin
                        o_dq_oe <= 1'b0;
                        cyc.ack <= 1'b1;
                        state_r <= E_IDLE;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                default:
                    state_r <= E_IDLE;
            endcase
        end
    end

    a_we_pulse_width: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n || !i_clk_en)
        $fell(o_we_n) |-> (!o_we_n)[*5] ##1 o_we_n) else $error("write strobe width wrong");
    a_dq_driven_strobe: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !o_we_n |-> (o_dq_oe && !o_ce_n && o_oe_n)) else $error("data not driven in strobe");
endmodule

/* flash_program_host.sv */
// Host controller that programs a parallel NOR flash by word or by write buffer
// Notes on behaviour
// - Word program: two unlocks, setup, address/data; a lock overlay start skips the two unlocks and begins at setup
// - Buffered program stays inside one line
// - Prefer whole pages, each written once
// - Unlocks AA at 555, 55 at 2AA
// - Write-to-buffer code at target sector address
// - Word count minus one, at most 255
// - Later loads sequential inside selected line
// - Confirm code right after last load
// - Poll bit 5 fail, bit 1 abort; reset
`timescale 1ns/1ps
module flash_program_host #(
    parameter int ADDR_W = 26
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [flash_prog_pkg::DQ_W-1:0] i_flash_dq_in,
    output logic [flash_prog_pkg::DQ_W-1:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    output logic [ADDR_W-1:0] o_flash_addr,
    output logic o_flash_ce_n,
    output logic o_flash_we_n,
    output logic o_flash_oe_n,
    output logic o_flash_reset_n,
    input wire logic i_ready_busy_output
);
    import flash_prog_pkg::*;

    if (ADDR_W < 12 || ADDR_W > 32 || LINE_LSB != 8)
    begin : g_bad_param
        $error("flash_program_host: ADDR_W must lie in 12..32");
    end

    flash_cycle_if #(.ADDR_W(ADDR_W)) cyc();

    flash_cycle_engine #(.ADDR_W(ADDR_W)) u_engine (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .cyc(cyc),
        .i_dq_in(i_flash_dq_in),
        .o_dq_out(o_flash_dq_out),
        .o_dq_oe(o_flash_dq_oe),
        .o_addr(o_flash_addr),
        .o_ce_n(o_flash_ce_n),
        .o_we_n(o_flash_we_n),
        .o_oe_n(o_flash_oe_n)
    );

    // 0 unmapped, 1 ctrl, 2 status, 3 addr, 4 count, 5 buffer window
    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        reg_sel = 3'h0;
        if (a[1:0] == 2'h0)
        begin
            if (a == REG_CTRL)
                reg_sel = 3'h1;
            else if (a == REG_STATUS)
                reg_sel = 3'h2;
            else if (a == REG_ADDR)
                reg_sel = 3'h3;
            else if (a == REG_COUNT)
                reg_sel = 3'h4;
            else if (a[11:10] == REG_BUF_BASE[11:10])
                reg_sel = 3'h5;
        end
    endfunction

    seq_state_t state_r;
    logic rdy_r;
    logic [31:0] prdata_r;
    logic slverr_r;
    logic [2:0] ctrl_r;
    logic [ADDR_W-1:0] base_r;
    logic [7:0] count_r;
    logic [7:0] idx_r;
    logic [7:0] left_r;
    logic [7:0] tmr_r;
    logic rst_seq_r;
    logic done_r;
    logic fail_r;
    logic abort_r;
    logic refused_r;
    logic [15:0] buf_mem [LINE_WORDS];

    logic busy;
    logic wr_fire;
    logic [2:0] wsel;
    logic start_req;
    logic start_ok;
    logic poll_ack;
    logic ev_fail;
    logic ev_abort;
    logic ev_done;
    logic flash_rst;
    logic poll_match;

    assign busy = (state_r != S_IDLE);
    assign o_pready = i_psel & i_penable & rdy_r;
    assign o_pslverr = o_pready & slverr_r;
    assign o_prdata = prdata_r;
    // Control keeps bits 3..1 at 2..0
    assign flash_rst = ctrl_r[CTRL_FLASH_RST_BIT - CTRL_BUFFER_BIT];
    assign o_flash_reset_n = !flash_rst;
    assign wr_fire = o_pready & i_pwrite;
    assign wsel = reg_sel(i_paddr);
    assign start_req = wr_fire && wsel == 3'h1 && i_pwdata[CTRL_START_BIT];
    // Refuse a line-crossing load, buffer mode in a lock overlay, or a busy start
    assign start_ok = start_req && !busy && !flash_rst
        && !(i_pwdata[CTRL_BUFFER_BIT] && i_pwdata[CTRL_OVERLAY_BIT])
        && !(i_pwdata[CTRL_BUFFER_BIT]
        && ({1'b0, base_r[LINE_LSB-1:0]} + {1'b0, count_r}) > {1'b0, COUNT_MAX});
    assign poll_ack = (state_r == S_POLL) && cyc.ack;
    // Bit 7 reads inverted until the array holds the last word written
    assign poll_match = cyc.rdata[COMPLETION_POLL_BIT]
        == buf_mem[idx_r][COMPLETION_POLL_BIT];
    assign ev_fail = poll_ack && !poll_match && cyc.rdata[FAIL_POLL_BIT];
    assign ev_abort = poll_ack && !poll_match && !cyc.rdata[FAIL_POLL_BIT]
        && cyc.rdata[ABORT_POLL_BIT];
    assign ev_done = poll_ack && poll_match && i_ready_busy_output;

    // APB slave: answer in the first access cycle, read data caught at setup
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdy_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            rdy_r <= i_psel & !i_penable;
            if (i_psel && !i_penable)
            begin
                slverr_r <= (wsel == 3'h0);
                case (wsel)
                    3'h1: prdata_r <= {29'h0, ctrl_r};
                    3'h2: prdata_r <= {27'h0, refused_r, abort_r, fail_r, done_r, busy};
                    3'h3: prdata_r <= 32'(base_r);
                    3'h4: prdata_r <= {24'h0, count_r};
                    3'h5: prdata_r <= {16'h0, buf_mem[i_paddr[BUF_IDX_LSB+7:BUF_IDX_LSB]]};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Setup held while busy so the running sequence sees stable values
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl_r <= CTRL_RESET_VAL;
            base_r <= '0;
            count_r <= 8'h00;
        end
        else if (i_clk_en && wr_fire)
        begin
            // Only the reset bit may change under a running sequence
            if (wsel == 3'h1 && !busy)
                ctrl_r <= i_pwdata[CTRL_FLASH_RST_BIT:CTRL_BUFFER_BIT];
            else if (wsel == 3'h1)
                ctrl_r[CTRL_FLASH_RST_BIT - CTRL_BUFFER_BIT] <= i_pwdata[CTRL_FLASH_RST_BIT];
            if (wsel == 3'h3 && !busy)
                base_r <= i_pwdata[ADDR_W-1:0];
            if (wsel == 3'h4 && !busy)
                count_r <= i_pwdata[7:0];
        end
    end

    // Words not rewritten keep their old contents and go out to the flash as they stand
    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && wr_fire && wsel == 3'h5 && !busy)
            buf_mem[i_paddr[BUF_IDX_LSB+7:BUF_IDX_LSB]] <= i_pwdata[15:0];
    end

    // Sticky status, write one to clear, fail also cleared by a done; a same-cycle event wins
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            abort_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (ev_done)
                done_r <= 1'b1;
            else if (wr_fire && wsel == 3'h2 && i_pwdata[STAT_DONE_BIT])
                done_r <= 1'b0;
            if (ev_fail || ev_abort)
                fail_r <= 1'b1;
            else if (ev_done || (wr_fire && wsel == 3'h2 && i_pwdata[STAT_FAIL_BIT]))
                fail_r <= 1'b0;
            if (ev_abort)
                abort_r <= 1'b1;
            else if (wr_fire && wsel == 3'h2 && i_pwdata[STAT_ABORT_BIT])
                abort_r <= 1'b0;
            if (start_req && !start_ok)
                refused_r <= 1'b1;
            else if (wr_fire && wsel == 3'h2 && i_pwdata[STAT_REFUSED_BIT])
                refused_r <= 1'b0;
        end
    end

    // Flash write or read requested by each state other than S_IDLE and S_WAIT_BUSY
    always_comb
    begin
        cyc.req = 1'b1;
        cyc.write = 1'b1;
        cyc.addr = base_r;
        cyc.wdata = 16'h0000;
        case (state_r)
            S_UNLOCK1:
            begin
                cyc.addr = ADDR_W'(UNLOCK_ADDR1);
                cyc.wdata = CMD_UNLOCK1;
            end
            S_UNLOCK2:
            begin
                cyc.addr = ADDR_W'(UNLOCK_ADDR2);
                cyc.wdata = CMD_UNLOCK2;
            end
            S_SETUP:
            begin
                cyc.addr = ctrl_r[0] ? base_r : ADDR_W'(UNLOCK_ADDR1);
                cyc.wdata = ctrl_r[0] ? CMD_WRITE_BUF : CMD_WORD_PGM;
            end
            S_COUNT: cyc.wdata = {8'h00, count_r};
            S_LOAD:
            begin
                cyc.addr = base_r + ADDR_W'(idx_r);
                cyc.wdata = buf_mem[idx_r];
            end
            S_CONFIRM: cyc.wdata = CMD_CONFIRM;
            S_WORD: cyc.wdata = buf_mem[8'h00];
            S_POLL:
            begin
                cyc.write = 1'b0;
                cyc.addr = base_r + ADDR_W'(idx_r);
            end
            S_RST_CMD:
            begin
                cyc.addr = ADDR_W'(UNLOCK_ADDR1);
                cyc.wdata = CMD_RESET;
            end
            default: cyc.req = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= S_IDLE;
            idx_r <= 8'h00;
            left_r <= 8'h00;
            tmr_r <= 8'h00;
            rst_seq_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            case (state_r)
                S_IDLE:
                    if (start_ok)
                    begin
                        idx_r <= 8'h00;
                        rst_seq_r <= 1'b0;
                        // Lock overlays take the word program bare
                        if (i_pwdata[CTRL_OVERLAY_BIT] && !i_pwdata[CTRL_BUFFER_BIT])
                            state_r <= S_SETUP;
                        else
                            state_r <= S_UNLOCK1;
                    end
                S_UNLOCK1:
                    if (cyc.ack)
                        state_r <= S_UNLOCK2;
                S_UNLOCK2:
                    if (cyc.ack)
                        state_r <= rst_seq_r ? S_RST_CMD : S_SETUP;
                S_SETUP:
                    if (cyc.ack)
                        state_r <= ctrl_r[0] ? S_COUNT : S_WORD;
                S_COUNT:
                    if (cyc.ack)
                    begin
                        left_r <= count_r;
                        state_r <= S_LOAD;
                    end
                S_LOAD:
                    if (cyc.ack)
                    begin
                        if (left_r == 8'h00)
                            state_r <= S_CONFIRM;
                        else
                        begin
                            idx_r <= idx_r + 8'h01;
                            left_r <= left_r - 8'h01;
                        end
                    end
                S_CONFIRM, S_WORD:
                    if (cyc.ack)
                    begin
                        tmr_r <= BUSY_CYC;
                        state_r <= S_WAIT_BUSY;
                    end
                S_WAIT_BUSY:
                    // Ready pin lags the last write; no command is sent meanwhile
                    if (tmr_r <= 8'h01)
                        state_r <= S_POLL;
                    else
                        tmr_r <= tmr_r - 8'h01;
                S_POLL:
                    if (ev_fail)
                        state_r <= S_RST_CMD;
                    else if (ev_abort)
                    begin
                        rst_seq_r <= 1'b1;
                        state_r <= S_UNLOCK1;
                    end
                    else if (ev_done)
                        state_r <= S_IDLE;
                S_RST_CMD:
                    if (cyc.ack)
                        state_r <= S_IDLE;
                default:
                    state_r <= S_IDLE;
            endcase
            if (flash_rst)
                state_r <= S_IDLE;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n || !i_clk_en || flash_rst);

    sequence s_unlocked;
        state_r == S_UNLOCK2 && cyc.ack && !rst_seq_r;
    endsequence
    sequence s_last_load;
        state_r == S_LOAD && cyc.ack && left_r == 8'h00;
    endsequence

    a_unlock_pair: assert property ((state_r == S_UNLOCK1 && cyc.ack) |=> state_r == S_UNLOCK2)
        else $error("second unlock skipped");
    a_setup_after_unlock: assert property (s_unlocked |=> state_r == S_SETUP && cyc.req)
        else $error("setup not after unlocks");
    a_count_value: assert property ((state_r == S_COUNT && cyc.req) |-> cyc.wdata == {8'h00, count_r})
        else $error("word count wrong");
    a_load_in_line: assert property ((state_r == S_LOAD && cyc.req)
        |-> cyc.addr[ADDR_W-1:LINE_LSB] == base_r[ADDR_W-1:LINE_LSB])
        else $error("load outside line");
    a_confirm_next: assert property (s_last_load |=> state_r == S_CONFIRM ##[1:40] cyc.ack)
        else $error("confirm not after last load");
    a_silent_busy: assert property ((state_r == S_WAIT_BUSY) |-> !cyc.req && !cyc.ack)
        else $error("command while busy");
    a_fail_reset: assert property (ev_fail |=> state_r == S_RST_CMD && cyc.wdata == CMD_RESET)
        else $error("no reset after failure");
    a_abort_flags: assert property (ev_abort |=> fail_r && abort_r && state_r == S_UNLOCK1)
        else $error("abort not flagged");
    a_busy_refuse: assert property ((busy && start_req) |=> refused_r && $stable(base_r))
        else $error("start taken while busy");
endmodule

/* flash_device_model.sv */
// Behavioural flash that answers word and buffered program sequences
`timescale 1ns/1ps
module flash_device_model (
    input wire logic [25:0] i_a,
    input wire logic [15:0] i_d,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_rst_n,
    output logic [15:0] o_d,
    output logic o_rdy
);
    import flash_prog_pkg::*;
    logic [15:0] mem [int];
    logic [15:0] wb [int];
    bit ecc_off [int];
    int st, cnt, sa, ln, a;
    bit ab, fl, ab_inj, fl_inj;
    logic [15:0] last = 16'hA5A5;
    logic [15:0] pd = 16'hFFFF;
    initial o_rdy = 1;
    function automatic logic [15:0] rd(input int x);
        return mem.exists(x) ? mem[x] : 16'hFFFF;
    endfunction
    // Released bus shows the inverse of the last value, never a stale copy
    // Status word with bit 7 inverted while busy, failed or aborted
    always @*
        o_d = (i_ce_n | i_oe_n) ? ~last : (ab | fl | !o_rdy)
            ? {8'h00, ~pd[7], 1'b0, fl, 3'b000, ab, 1'b0} : rd(int'(i_a));
    always @(posedge i_oe_n)
        last = o_d;
    always @(negedge i_rst_n)
        st = 0;
    // Sampled after the strobe fall; the rising edges of ce and we may race
    always @(negedge i_we_n)
    begin
        #1;
        a = int'(i_a);
        if (!i_ce_n && i_rst_n)
        begin
            if (st < 3 && i_d == CMD_RESET)
            begin
                st = 0;
                ab = 0;
                fl = 0;
            end
            else
                case (st)
                    0: st = (i_d == CMD_UNLOCK1 && i_a[11:0] == 12'h555) ? 1 :
                        (i_d == CMD_WORD_PGM) ? 3 : 0;
                    1: st = (i_d == CMD_UNLOCK2 && i_a[11:0] == 12'h2AA) ? 2 : 0;
                    2:
                    begin
                        st = i_d == CMD_WORD_PGM ? 3 : i_d == CMD_WRITE_BUF ? 4 : 0;
                        sa = a >> 16;
                        ln = -1;
                        wb.delete();
                    end
                    3:
                    begin
                        mem[a] = rd(a) & i_d;
                        pd = i_d;
                        ecc_off[a >> 4] = 1;
                        st = 7;
                    end
                    4:
                    begin
                        cnt = i_d;
                        st = i_d > 16'h00FF ? 8 : 5;
                    end
                    5:
                    begin
                        if (ln < 0 && (a >> 16) == sa)
                            ln = a >> 8;
                        if ((a >> 8) != ln || (wb.num() > 0 && !wb.exists(a - 1)))
                            st = 8;
                        else
                        begin
                            wb[a] = i_d;
                            pd = i_d;
                            st = cnt == 0 ? 6 : 5;
                            cnt--;
                        end
                    end
                    6:
                    begin
                        st = (i_d == CMD_CONFIRM && !ab_inj) ? 7 : 8;
                        foreach (wb[k])
                            if (st == 7)
                            begin
                                if (mem.exists(k))
                                    ecc_off[k >> 4] = 1;
                                mem[k] = rd(k) & wb[k];
                            end
                    end
                    default: st = 0;
                endcase
            if (st == 8)
            begin
                ab = 1;
                st = 0;
            end
            // Writes during the busy wait are lost, as the real part ignores them
            if (st == 7)
            begin
                o_rdy = 0;
                #400;
                fl = fl_inj;
                o_rdy = 1;
                st = 0;
            end
        end
    end
endmodule

/* flash_program_host_tb_top.sv */
// Bench for the flash program host with a behavioural flash
`timescale 1ns/1ps
module flash_program_host_tb_top;
    import flash_prog_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic psel = 0;
    logic pen = 0;
    logic pwr = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h00000000;
    logic [31:0] prd, r;
    logic rdy, err, e, dq_oe, ce_n, we_n, oe_n, frst_n, ready;
    logic [15:0] dq_out, dev_dq;
    logic [15:0] wd [256];
    logic [15:0] sh [int];
    logic [25:0] fa, a;
    logic [7:0] o, c;
    int fails = 0;
    int checks = 0;
    always #4 clk = ~clk;
    flash_program_host uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .o_flash_dq_out(dq_out),
        .i_flash_dq_in(dq_oe ? dq_out : dev_dq), .o_flash_dq_oe(dq_oe), .o_flash_addr(fa),
        .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n),
        .o_flash_reset_n(frst_n), .i_ready_busy_output(ready));
    flash_device_model dev (.i_a(fa), .i_d(dq_out), .i_ce_n(ce_n), .i_we_n(we_n),
        .i_oe_n(oe_n), .i_rst_n(frst_n), .o_d(dev_dq), .o_rdy(ready));
    function automatic logic [15:0] ex(input int x);
        return sh.exists(x) ? sh[x] : 16'hFFFF;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= ad;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        r = prd;
        e = err;
        psel <= 0;
        pen <= 0;
    endtask
    // Fail bit is left set on purpose, so a later success must clear it
    task automatic prog(input logic [2:0] m, input logic [25:0] ad, input logic [7:0] n8,
        input bit wt);
        apb(1, REG_STATUS, 32'h0000001A);
        for (int i = 0; i <= n8; i++)
        begin
            wd[i] = 16'($urandom);
            apb(1, REG_BUF_BASE + 12'(i * 4), {16'h0000, wd[i]});
        end
        apb(1, REG_ADDR, {6'h00, ad});
        apb(1, REG_COUNT, {24'h000000, n8});
        apb(1, REG_CTRL, {28'h0000000, m, 1'b1});
        for (int n = 0; n < 3000 && wt; n++)
        begin
            apb(0, REG_STATUS, 0);
            if (r[STAT_BUSY_BIT] === 1'b0)
                break;
        end
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #600000;
        fails++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'h3C4CF49C));
        repeat (2) @(posedge clk);
        rst_n <= 1;
        apb(0, REG_STATUS, 0);
        chk(r, 0);
        apb(0, 12'hFF0, 0);
        chk(e, 1);
        dev.fl_inj = 1;
        prog(3'b000, 26'h0001234, 0, 1);
        chk(r[STAT_FAIL_BIT], 1);
        dev.fl_inj = 0;
        dev.ab_inj = 1;
        prog(3'b001, 26'h0002000, 3, 1);
        chk(r[STAT_ABORT_BIT], 1);
        chk(dev.ab, 0);
        dev.ab_inj = 0;
        for (int k = 0; k < 8; k++)
        begin
            o = k == 2 ? 8'hFF : k == 3 ? 8'h00 : 8'($urandom);
            c = k < 3 ? 8'h00 : k == 3 ? 8'hFF : 8'($urandom_range(255 - o));
            a = 26'($urandom);
            a = {a[25:8], o};
            prog(k < 2 ? {1'b0, k[0], 1'b0} : 3'b001, a, c, 1);
            chk(r[4:0], 5'h02);
            for (int i = 0; i <= c; i++)
            begin
                sh[int'(a) + i] = ex(int'(a) + i) & wd[i];
                chk(dev.rd(int'(a) + i), sh[int'(a) + i]);
            end
        end
        prog(3'b001, {a[25:8], 8'hF0}, 8'h20, 1);
        chk(r[4:0], 5'h10);
        prog(3'b011, a, 0, 1);
        chk(r[4:0], 5'h10);
        prog(3'b001, {a[25:8], 8'h00}, 8'hFF, 0);
        apb(1, REG_CTRL, 32'h00000003);
        apb(0, REG_STATUS, 0);
        chk({r[STAT_REFUSED_BIT], r[STAT_BUSY_BIT]}, 2'b11);
        apb(1, REG_CTRL, 32'h00000008);
        @(negedge clk);
        chk(frst_n, 0);
        apb(0, REG_STATUS, 0);
        chk(r[STAT_BUSY_BIT], 0);
        apb(1, REG_CTRL, 0);
        @(negedge clk);
        chk(frst_n, 1);
        apb(1, REG_STATUS, 32'h0000001F);
        apb(0, REG_STATUS, 0);
        chk(r, 0);
        summarize();
    end
endmodule
